// >>> rtl/pbh_pkg.sv
// Functional notes
// - initiator holds IRDY until data phase ends
// - target holds TRDY until data phase ends
// - drive inactive one cycle before release
// - accepting target asserts DEVSEL
// - master abort without DEVSEL within 5 clocks
// - initiator honours target STOP request
// - no upstream locked sequences from LOCK
// - type 0 config claimed only with IDSEL
// - PERR on received data parity error
// - SERR is a shared wired-OR line
// - SERR on address or posted-write parity error
// - SERR on posted write abort or discard
// - SERR on delayed discard or master timeout
// - SERR for AER errors in transparent mode
// - FRAME marks transaction, drops for last phase
// - PAR is even parity over AD and CBE
//
// Purpose: shared constants and types of the pci bus handshake block
// Assumes: one 10 MHz clock, all pins synchronised before use
// Notes:   timing figures are in bus clocks
`default_nettype none

package pbh_pkg;
   localparam int unsigned CLK_MHZ     = 10;
   localparam int unsigned MABORT_CLKS = 5;        // devsel wait after frame
   localparam logic [2:0]  MABORT_CNT  = 3'(MABORT_CLKS);
   localparam logic [2:0]  CMD_CFG_HI  = 3'h5;     // cbe[3:1] of config rd/wr
   localparam logic [1:0]  CFG_TYPE0   = 2'h0;     // ad[1:0] of type 0 access
   localparam int unsigned PIN_W       = 45;       // synchronised pin bundle
   localparam int unsigned AD_W        = 32;
   localparam int unsigned CBE_W       = 4;

   typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} pbh_mst_t;
   typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} pbh_tgt_t;
endpackage

`default_nettype wire

// >>> rtl/pbh_err_if.sv
// Purpose: carries error events to the system error generator and its pin state back
// Assumes: one clock domain
// Notes:   all members are flip-flop outputs of their driver
`default_nettype none

interface pbh_err_if;
   logic addr_perr;    // address parity error pulse
   logic pw_mabort;    // posted write master abort pulse
   logic line_low;     // synchronised serr line level, active high
   logic serr_n;
   logic serr_oe;
   logic serr_seen;

   modport ctl (output addr_perr, output pw_mabort, output line_low,
                input serr_n, input serr_oe, input serr_seen);
   modport gen (input addr_perr, input pw_mabort, input line_low,
                output serr_n, output serr_oe, output serr_seen);
endinterface

`default_nettype wire

// >>> rtl/pbh_serr_gen.sv
// Purpose: collects system error events and pulses the open drain serr line
// Assumes: events are one-cycle pulses on clk_i
// Notes:   the line is only ever pulled low, never driven high
`default_nettype none

module pbh_serr_gen
   import pbh_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   pbh_err_if.gen    err,
   input  wire logic serr_en_i,
   input  wire logic transparent_i,
   input  wire logic pw_perr_i,
   input  wire logic pw_tabort_i,
   input  wire logic pw_discard_i,
   input  wire logic dw_discard_i,
   input  wire logic dr_discard_i,
   input  wire logic dt_timeout_i,
   input  wire logic aer_err_i
);
   logic       ev_par;
   logic       ev_pw;
   logic       ev_dly;
   logic       ev_aer;
   logic       ev_any;
   logic [2:0] own_hist_ff;

   // event classes gated together by the single enable
   assign ev_par = err.addr_perr | pw_perr_i;
   assign ev_pw  = err.pw_mabort | pw_tabort_i | pw_discard_i;
   assign ev_dly = dw_discard_i | dr_discard_i | dt_timeout_i;
   assign ev_aer = aer_err_i & transparent_i;
   assign ev_any = serr_en_i & (ev_par | ev_pw | ev_dly | ev_aer);

   // open drain: output level is always low, only the enable moves
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         err.serr_oe <= 1'b0;
         err.serr_n  <= 1'b0;
      end else begin
         err.serr_oe <= ev_any;
         err.serr_n  <= 1'b0;
      end
   end

   // own pulse echoes back through the synchroniser, so mask it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         own_hist_ff   <= 3'h0;
         err.serr_seen <= 1'b0;
      end else begin
         own_hist_ff   <= {own_hist_ff[1:0], err.serr_oe};
         err.serr_seen <= err.line_low & ~(|own_hist_ff);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   serr_fire_a: assert property (ev_any |=> (err.serr_oe && !err.serr_n))
      else $error("serr not pulled after enabled event");
   serr_gate_a: assert property (!serr_en_i |=> !err.serr_oe)
      else $error("serr driven while reporting disabled");
   serr_aer_a: assert property ((serr_en_i && aer_err_i && !transparent_i && !ev_par && !ev_pw && !ev_dly)
                                |=> !err.serr_oe)
      else $error("aer error raised serr outside transparent mode");
   serr_dly_a: assert property ((serr_en_i && $rose(dt_timeout_i)) |=> err.serr_oe)
      else $error("delayed timeout did not raise serr");
   serr_cv: cover property (ev_any ##1 err.serr_oe);
endmodule

`default_nettype wire

// >>> rtl/pbh_bus_ctl.sv
// Purpose: pci bus handshake, target claim, master abort, parity and error pins
// Assumes: pins pass two flip-flops; single data phase per master request
// Notes:   synchroniser latency shifts all pin reactions by two clocks
`default_nettype none

module pbh_bus_ctl (
   input  wire logic                       clk_i,
   input  wire logic                       reset_n_i,
   // bus pins, inputs
   input  wire logic                       frame_n_i,
   input  wire logic                       irdy_n_i,
   input  wire logic                       trdy_n_i,
   input  wire logic                       devsel_n_i,
   input  wire logic                       stop_n_i,
   input  wire logic                       lock_n_i,
   input  wire logic                       idsel_i,
   input  wire logic                       serr_n_i,
   input  wire logic                       par_i,
   input  wire logic [pbh_pkg::AD_W-1:0]   ad_i,
   input  wire logic [pbh_pkg::CBE_W-1:0]  cbe_n_i,
   // bus pins, outputs and enables
   output logic                            frame_n_o,
   output logic                            frame_oe_o,
   output logic                            irdy_n_o,
   output logic                            irdy_oe_o,
   output logic                            trdy_n_o,
   output logic                            trdy_oe_o,
   output logic                            devsel_n_o,
   output logic                            devsel_oe_o,
   output logic                            stop_n_o,
   output logic                            stop_oe_o,
   output logic                            perr_n_o,
   output logic                            perr_oe_o,
   output logic                            serr_n_o,
   output logic                            serr_oe_o,
   // master side user port
   input  wire logic                       mst_start_i,
   input  wire logic                       mst_write_i,
   input  wire logic                       mst_posted_i,
   input  wire logic                       mst_rdy_i,
   output logic                            mst_done_o,
   output logic                            mst_abort_o,
   output logic                            mst_stop_o,
   // target side user port
   input  wire logic                       tgt_hit_i,
   input  wire logic                       tgt_rdy_i,
   input  wire logic                       tgt_stop_i,
   output logic                            tgt_start_o,
   output logic                            tgt_cfg_o,
   output logic                            tgt_xfer_o,
   output logic                            lock_ignored_o,
   // error control and events
   input  wire logic                       perr_en_i,
   input  wire logic                       serr_en_i,
   input  wire logic                       transparent_i,
   input  wire logic                       pw_perr_i,
   input  wire logic                       pw_tabort_i,
   input  wire logic                       pw_discard_i,
   input  wire logic                       dw_discard_i,
   input  wire logic                       dr_discard_i,
   input  wire logic                       dt_timeout_i,
   input  wire logic                       aer_err_i,
   output logic                            data_perr_o,
   output logic                            serr_seen_o
);
   import pbh_pkg::*;

   logic [PIN_W-1:0]  meta_ff;
   logic [PIN_W-1:0]  sync_ff;
   logic              frame_s, irdy_s, trdy_s, devsel_s, stop_s, lock_s, idsel_s, par_s;
   logic [AD_W-1:0]   ad_s;
   logic [CBE_W-1:0]  cbe_s;
   logic              frame_q_ff;
   logic              frame_fall;
   logic              cfg0;
   logic              claim;
   pbh_mst_t          mst_st_ff;
   pbh_tgt_t          tgt_st_ff;
   logic [2:0]        cnt_ff;
   logic              tgt_wr_ff;
   logic              chk_vld_ff;
   logic              chk_par_ff;
   logic              chk_addr_ff;
   logic              perr_hold_ff;
   logic              t_xfer;
   logic              t_end;
   logic              m_xfer;
   logic              m_capt;
   pbh_err_if         err ();

   // two-stage synchroniser; only sync_ff is read by logic
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= {frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i, stop_n_i, lock_n_i,
                     idsel_i, serr_n_i, par_i, ad_i, cbe_n_i};
         sync_ff <= meta_ff;
      end
   end
   assign {frame_s, irdy_s, trdy_s, devsel_s, stop_s, lock_s, idsel_s} = sync_ff[PIN_W-1:PIN_W-7];
   assign par_s = sync_ff[AD_W+CBE_W];
   assign ad_s  = sync_ff[AD_W+CBE_W-1:CBE_W];
   assign cbe_s = sync_ff[CBE_W-1:0];

   // address phase decode, config type 0 needs idsel as chip select
   assign frame_fall = ~frame_s & frame_q_ff;
   assign cfg0  = (cbe_s[3:1] == CMD_CFG_HI) && (ad_s[1:0] == CFG_TYPE0);
   assign claim = cfg0 ? idsel_s : ((cbe_s[3:1] != CMD_CFG_HI) & tgt_hit_i);
   assign t_xfer = ~irdy_s & ~trdy_n_o;
   assign t_end  = (t_xfer & frame_s) | (~irdy_s & ~stop_n_o) | (frame_s & irdy_s);
   assign m_xfer = ~devsel_s & ~trdy_s & ~irdy_n_o;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) frame_q_ff <= 1'b1;
      else            frame_q_ff <= frame_s;
   end

   // master: address, one data phase, then one inactive cycle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mst_st_ff   <= M_IDLE;
         frame_n_o   <= 1'b1;
         frame_oe_o  <= 1'b0;
         irdy_n_o    <= 1'b1;
         irdy_oe_o   <= 1'b0;
         cnt_ff      <= 3'h0;
         mst_done_o  <= 1'b0;
         mst_abort_o <= 1'b0;
         mst_stop_o  <= 1'b0;
      end else begin
         mst_done_o  <= 1'b0;
         mst_abort_o <= 1'b0;
         mst_stop_o  <= 1'b0;
         unique case (mst_st_ff)
            M_IDLE: if (mst_start_i && frame_s && irdy_s && tgt_st_ff == T_IDLE) begin
               frame_n_o  <= 1'b0;
               frame_oe_o <= 1'b1;
               irdy_oe_o  <= 1'b1;
               cnt_ff     <= 3'h0;
               mst_st_ff  <= M_ADDR;
            end
            M_ADDR: begin
               frame_n_o <= 1'b1;
               irdy_n_o  <= ~mst_rdy_i;
               cnt_ff    <= cnt_ff + 3'h1;
               mst_st_ff <= M_DATA;
            end
            M_DATA: begin
               if (devsel_s && cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
               if (mst_rdy_i) irdy_n_o <= 1'b0;
               if (!devsel_s && !stop_s) begin
                  mst_stop_o <= 1'b1;
                  irdy_n_o   <= 1'b1;
                  mst_st_ff  <= M_TURN;
               end else if (m_xfer) begin
                  mst_done_o <= 1'b1;
                  irdy_n_o   <= 1'b1;
                  mst_st_ff  <= M_TURN;
               end else if (devsel_s && cnt_ff >= MABORT_CNT) begin
                  mst_abort_o <= 1'b1;
                  irdy_n_o    <= 1'b1;
                  mst_st_ff   <= M_TURN;
               end
            end
            M_TURN: begin
               frame_oe_o <= 1'b0;
               irdy_oe_o  <= 1'b0;
               mst_st_ff  <= M_IDLE;
            end
         endcase
      end
   end

   // posted write that ends in master abort is a system error source
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) err.pw_mabort <= 1'b0;
      else            err.pw_mabort <= mst_st_ff == M_DATA && devsel_s && cnt_ff >= MABORT_CNT
                                       && mst_posted_i && mst_write_i;
   end

   // target: claim, ready handshake, stop, inactive cycle before release
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tgt_st_ff      <= T_IDLE;
         trdy_n_o       <= 1'b1;
         trdy_oe_o      <= 1'b0;
         devsel_n_o     <= 1'b1;
         devsel_oe_o    <= 1'b0;
         stop_n_o       <= 1'b1;
         stop_oe_o      <= 1'b0;
         tgt_wr_ff      <= 1'b0;
         tgt_start_o    <= 1'b0;
         tgt_cfg_o      <= 1'b0;
         tgt_xfer_o     <= 1'b0;
         lock_ignored_o <= 1'b0;
      end else begin
         tgt_start_o    <= 1'b0;
         tgt_xfer_o     <= 1'b0;
         lock_ignored_o <= 1'b0;
         unique case (tgt_st_ff)
            T_IDLE: if (frame_fall && claim && mst_st_ff == M_IDLE) begin
               devsel_n_o     <= 1'b0;
               devsel_oe_o    <= 1'b1;
               trdy_oe_o      <= 1'b1;
               stop_oe_o      <= 1'b1;
               tgt_wr_ff      <= cbe_s[0];
               tgt_start_o    <= 1'b1;
               tgt_cfg_o      <= cfg0;
               // lock is never forwarded; the access runs as a plain one
               lock_ignored_o <= ~lock_s;
               tgt_st_ff      <= T_DATA;
            end
            T_DATA: begin
               if (tgt_rdy_i) trdy_n_o <= 1'b0;
               if (tgt_stop_i) stop_n_o <= 1'b0;
               tgt_xfer_o <= t_xfer;
               if (t_end) begin
                  trdy_n_o   <= 1'b1;
                  devsel_n_o <= 1'b1;
                  stop_n_o   <= 1'b1;
                  tgt_st_ff  <= T_TURN;
               end else if (t_xfer) begin
                  trdy_n_o <= ~tgt_rdy_i;
               end
            end
            T_TURN: begin
               trdy_oe_o   <= 1'b0;
               devsel_oe_o <= 1'b0;
               stop_oe_o   <= 1'b0;
               tgt_st_ff   <= T_IDLE;
            end
            default: tgt_st_ff <= T_IDLE;
         endcase
      end
   end

   // parity capture: par follows its data by one clock
   assign m_capt = (mst_st_ff == M_DATA) && m_xfer && !mst_write_i;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chk_vld_ff  <= 1'b0;
         chk_addr_ff <= 1'b0;
         chk_par_ff  <= 1'b0;
      end else begin
         chk_vld_ff  <= (tgt_st_ff == T_DATA && t_xfer && tgt_wr_ff) || m_capt;
         chk_addr_ff <= frame_fall;
         chk_par_ff  <= ^{ad_s, cbe_s};
      end
   end

   // perr: one clock low, one clock high, then released
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         perr_n_o       <= 1'b1;
         perr_oe_o      <= 1'b0;
         perr_hold_ff   <= 1'b0;
         data_perr_o    <= 1'b0;
         err.addr_perr  <= 1'b0;
      end else begin
         data_perr_o   <= chk_vld_ff && (par_s != chk_par_ff);
         err.addr_perr <= chk_addr_ff && (par_s != chk_par_ff);
         if (chk_vld_ff && (par_s != chk_par_ff) && perr_en_i) begin
            perr_n_o     <= 1'b0;
            perr_oe_o    <= 1'b1;
            perr_hold_ff <= 1'b1;
         end else if (perr_hold_ff) begin
            perr_n_o     <= 1'b1;
            perr_hold_ff <= 1'b0;
         end else begin
            perr_oe_o <= 1'b0;
         end
      end
   end

   // shared serr line is seen level-high when any agent pulls it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) err.line_low <= 1'b0;
      else            err.line_low <= ~sync_ff[AD_W+CBE_W+1];
   end

   pbh_serr_gen u_serr (
      .clk_i         (clk_i),
      .reset_n_i     (reset_n_i),
      .err           (err),
      .serr_en_i     (serr_en_i),
      .transparent_i (transparent_i),
      .pw_perr_i     (pw_perr_i),
      .pw_tabort_i   (pw_tabort_i),
      .pw_discard_i  (pw_discard_i),
      .dw_discard_i  (dw_discard_i),
      .dr_discard_i  (dr_discard_i),
      .dt_timeout_i  (dt_timeout_i),
      .aer_err_i     (aer_err_i)
   );
   assign serr_n_o    = err.serr_n;
   assign serr_oe_o   = err.serr_oe;
   assign serr_seen_o = err.serr_seen;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   irdy_hold_a: assert property ((mst_st_ff == M_DATA && !irdy_n_o && devsel_s && cnt_ff < MABORT_CNT)
                                 |=> !irdy_n_o)
      else $error("irdy released before data phase end");
   trdy_hold_a: assert property ((tgt_st_ff == T_DATA && !trdy_n_o && irdy_s && !frame_s)
                                 |=> !trdy_n_o)
      else $error("trdy released before data phase end");
   tgt_release_a: assert property ($fell(devsel_oe_o) |-> ($past(devsel_n_o) && $past(trdy_n_o)
                                   && $past(stop_n_o)))
      else $error("target pins released without inactive cycle");
   mst_release_a: assert property ($fell(irdy_oe_o) |-> ($past(irdy_n_o) && $past(frame_n_o)))
      else $error("master pins released without inactive cycle");
   cfg_claim_a: assert property ((tgt_st_ff == T_IDLE && mst_st_ff == M_IDLE && frame_fall && cfg0)
                                 |=> (devsel_oe_o == $past(idsel_s)) && (!devsel_n_o == $past(idsel_s)))
      else $error("type 0 config claim does not follow idsel");
   mabort_a: assert property ((mst_st_ff == M_ADDR) ##1 (devsel_s && mst_st_ff == M_DATA) [*5]
                              |=> (mst_abort_o && irdy_oe_o && irdy_n_o) ##1 !irdy_oe_o)
      else $error("no master abort after devsel timeout");
   stop_a: assert property ((mst_st_ff == M_DATA && !devsel_s && !stop_s) |=> (mst_stop_o && irdy_n_o))
      else $error("stop request not honoured");
   perr_a: assert property ((chk_vld_ff && par_s != chk_par_ff && perr_en_i)
                            |=> (!perr_n_o && perr_oe_o) ##1 (perr_n_o && perr_oe_o))
      else $error("perr not signalled on data parity error");
   devsel_a: assert property ($rose(tgt_start_o) |-> (!devsel_n_o && devsel_oe_o))
      else $error("accepted transaction without devsel");

   mst_done_cv: cover property (mst_st_ff == M_ADDR ##[1:8] mst_done_o);
   mst_abort_cv: cover property (mst_abort_o);
   cfg_claim_cv: cover property (tgt_start_o && tgt_cfg_o);
   perr_cv: cover property (!perr_n_o && perr_oe_o);
endmodule

`default_nettype wire

// >>> rtl/pbh_dummy_unused.sv
`default_nettype none
`default_nettype wire

// >>> dv/pbh_far_tgt.sv
// Purpose: far target that answers the bridge when it is bus master
// Assumes: levels seen are wire levels, lines pulled up when released
// Notes:   mode 0 claims and is ready, 1 stays silent, 2 claims and stops
`default_nettype none
module pbh_far_tgt (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       frame_n_i,
   input  wire logic       irdy_n_i,
   input  wire logic [1:0] mode_i,
   output logic            devsel_n_o,
   output logic            trdy_n_o,
   output logic            stop_n_o,
   output logic            oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] st_ff;   // 0 idle, 1 claimed, 2 driven inactive
   logic       irdy_ff; // initiator seen ready in this phase
   // claim on frame low; end only after irdy was low and rose again
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff <= 2'h0;
         irdy_ff <= 1'b0;
      end else if (st_ff == 2'h0) begin
         if (!frame_n_i && mode_i != 2'h1) st_ff <= 2'h1;
      end else if (st_ff == 2'h1) begin
         if (!irdy_n_i) irdy_ff <= 1'b1;
         if (irdy_ff && irdy_n_i) st_ff <= 2'h2;
      end else begin
         st_ff <= 2'h0;
         irdy_ff <= 1'b0;
      end
   end
   // one inactive cycle before release, so no floating lines mid-phase
   assign oe_o       = (st_ff != 2'h0);
   assign devsel_n_o = (st_ff != 2'h1);
   assign trdy_n_o   = !(st_ff == 2'h1 && mode_i == 2'h0);
   assign stop_n_o   = !(st_ff == 2'h1 && mode_i == 2'h2);
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench of the bus handshake block
// Assumes: pull-ups on all shared lines, inputs change at falling edge
// Notes:   pulses are caught in sticky bits, so windows are fixed
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("FAIL %0t mismatch", $time); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0, reset_n_i = 1'b0, frame_b = 1'b1, irdy_b = 1'b1, serr_b = 1'b1;
   logic lock_n_i = 1'b1, idsel_i = 1'b0, par_i = 1'b0, mst_start_i = 1'b0, mst_posted_i = 1'b0;
   logic tgt_rdy_i = 1'b1, serr_en_i = 1'b0, transparent_i = 1'b0;
   logic [31:0] ad_i = 32'h0;
   logic [3:0]  cbe_n_i = 4'hF;
   logic [6:0]  ev = 7'h0;
   logic [1:0]  mode = 2'h0;
   logic [9:0]  seen = 10'h0;
   logic [5:0]  p_oe = 6'h0, p_n = 6'h0;
   int n_errors = 0, compares = 0, cyc = 0;
   wire logic frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o, trdy_n_o, trdy_oe_o, devsel_n_o, devsel_oe_o;
   wire logic stop_n_o, stop_oe_o, perr_n_o, perr_oe_o, serr_n_o, serr_oe_o, mst_done_o, mst_abort_o;
   wire logic mst_stop_o, tgt_start_o, tgt_cfg_o, tgt_xfer_o, lock_ignored_o, data_perr_o, serr_seen_o;
   wire logic f_dev, f_trdy, f_stop, f_oe;
   // wire levels: whoever enables drives, otherwise the pull-up
   wire logic frame_w = frame_oe_o ? frame_n_o : frame_b;
   wire logic irdy_w = irdy_oe_o ? irdy_n_o : irdy_b;
   wire logic trdy_w = trdy_oe_o ? trdy_n_o : (f_oe ? f_trdy : 1'b1);
   wire logic dev_w = devsel_oe_o ? devsel_n_o : (f_oe ? f_dev : 1'b1);
   wire logic stop_w = stop_oe_o ? stop_n_o : (f_oe ? f_stop : 1'b1);
   wire logic serr_w = (serr_oe_o ? serr_n_o : 1'b1) & serr_b;
   wire logic [5:0] oe_v = {frame_oe_o, irdy_oe_o, trdy_oe_o, devsel_oe_o, stop_oe_o, perr_oe_o};
   wire logic [5:0] n_v = {frame_n_o, irdy_n_o, trdy_n_o, devsel_n_o, stop_n_o, perr_n_o};
   pbh_bus_ctl pbh_bus_ctl_i (.clk_i, .reset_n_i, .frame_n_i(frame_w), .irdy_n_i(irdy_w), .trdy_n_i(trdy_w),
      .devsel_n_i(dev_w), .stop_n_i(stop_w), .lock_n_i, .idsel_i, .serr_n_i(serr_w), .par_i, .ad_i, .cbe_n_i,
      .frame_n_o, .frame_oe_o, .irdy_n_o, .irdy_oe_o, .trdy_n_o, .trdy_oe_o, .devsel_n_o, .devsel_oe_o,
      .stop_n_o, .stop_oe_o, .perr_n_o, .perr_oe_o, .serr_n_o, .serr_oe_o, .mst_start_i, .mst_write_i(1'b1),
      .mst_posted_i, .mst_rdy_i(1'b1), .mst_done_o, .mst_abort_o, .mst_stop_o, .tgt_hit_i(1'b0), .tgt_rdy_i,
      .tgt_stop_i(1'b0), .tgt_start_o, .tgt_cfg_o, .tgt_xfer_o, .lock_ignored_o, .perr_en_i(1'b1), .serr_en_i,
      .transparent_i, .pw_perr_i(ev[0]), .pw_tabort_i(ev[1]), .pw_discard_i(ev[2]), .dw_discard_i(ev[3]),
      .dr_discard_i(ev[4]), .dt_timeout_i(ev[5]), .aer_err_i(ev[6]), .data_perr_o, .serr_seen_o);
   pbh_far_tgt pbh_far_tgt_i (.clk_i, .reset_n_i, .frame_n_i(frame_w), .irdy_n_i(irdy_w), .mode_i(mode),
      .devsel_n_o(f_dev), .trdy_n_o(f_trdy), .stop_n_o(f_stop), .oe_o(f_oe));
   always #50 clk_i = ~clk_i;
   // sticky pulse capture, cleared by each scenario
   always @(posedge clk_i) begin
      seen = seen | {perr_oe_o & !perr_n_o, data_perr_o, tgt_xfer_o, lock_ignored_o, tgt_start_o,
                     serr_seen_o, serr_oe_o, mst_stop_o, mst_abort_o, mst_done_o};
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         end_of_test();
      end
   end
   // any released bridge line other than serr must have been driven high the cycle before
   always @(negedge clk_i) begin
      for (int i = 0; i < 6; i++) if (p_oe[i] && !oe_v[i]) `CHK(p_n[i], 1'b1)
      p_oe = oe_v;
      p_n = n_v;
   end
   task automatic end_of_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_mst(input logic [1:0] m, input logic pst, input logic [3:0] e);
      mode = m;
      mst_posted_i = pst;
      serr_en_i = 1'b1;
      seen = '0;
      mst_start_i = 1'b1;
      @(negedge clk_i);
      mst_start_i = 1'b0;
      repeat (16) @(negedge clk_i);
      `CHK(seen[3:0], e)
   endtask
   task automatic t_ev(input int i, input logic en, input logic tr, input logic e);
      serr_en_i = en;
      transparent_i = tr;
      seen = '0;
      ev = 7'(1 << i);
      @(negedge clk_i);
      ev = 7'h0;
      repeat (5) @(negedge clk_i);
      `CHK(seen[3], e)
   endtask
   task automatic t_cfg(input logic sel);
      serr_en_i = 1'b0;
      seen = '0;
      idsel_i = sel;
      lock_n_i = 1'b0;
      cbe_n_i = 4'hB;
      ad_i = 32'h0000_0100;
      par_i = ^{32'h0000_0100, 4'hB};
      frame_b = 1'b0;
      @(negedge clk_i);
      frame_b = 1'b1;
      irdy_b = 1'b0;
      lock_n_i = 1'b1;
      cbe_n_i = 4'h0;
      ad_i = 32'h5A5A_0001;
      par_i = 1'b0;
      repeat (10) @(negedge clk_i);
      irdy_b = 1'b1;
      repeat (6) @(negedge clk_i);
      `CHK(seen[9:5], {5{sel}})
      `CHK(tgt_cfg_o, sel)
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_mst(2'h0, 1'b0, 4'h1);
      t_mst(2'h1, 1'b1, 4'hA);
      t_mst(2'h2, 1'b0, 4'h4);
      for (int i = 0; i < 7; i++) t_ev(i, 1'b1, 1'b1, 1'b1);
      for (int i = 0; i < 7; i++) t_ev(i, 1'b0, 1'b1, 1'b0);
      t_ev(6, 1'b1, 1'b0, 1'b0);
      t_cfg(1'b0);
      t_cfg(1'b1);
      serr_en_i = 1'b0;
      seen = '0;
      serr_b = 1'b0;
      @(negedge clk_i);
      serr_b = 1'b1;
      repeat (5) @(negedge clk_i);
      `CHK(seen[4], 1'b1)
      end_of_test();
   end
endmodule
`default_nettype wire
